// >>> common/offcore_filter_defs.svh
// Purpose : named offsets, field positions and reset values of the uncore request filter block
// Assumes : included by bare name from the package and the design files
// Notes   : definitions only
`ifndef OFFCORE_FILTER_DEFS_SVH
`define OFFCORE_FILTER_DEFS_SVH

// ----------------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------------
`define FILTER0_ADDR        32'h0000_01A6
`define FILTER1_ADDR        32'h0000_01A7

// ----------------------------------------------------------------------------
// filter field positions
// ----------------------------------------------------------------------------
`define REQ_LSB             0
`define REQ_MSB             15
`define RESP_LSB            16
`define RESP_MSB            30
`define SNOOP_LSB           31
`define SNOOP_MSB           37
`define OUTSTANDING_BIT     38

// writable bits: reserved 6, 32:31, 35 and 63:39 read as zero, and bit 38 also reads as zero in filter 1
`define FILTER0_WMASK       64'h0000_0076_7FFF_FFBF
`define FILTER1_WMASK       64'h0000_0036_7FFF_FFBF
`define FILTER_RESET        64'h0000_0000_0000_0000

// ----------------------------------------------------------------------------
// event selection
// ----------------------------------------------------------------------------
`define OFFCORE_EVENT_CODE  8'hB7
`define UNIT_MASK_FILTER0   8'h01
`define UNIT_MASK_FILTER1   8'h02

// ----------------------------------------------------------------------------
// global counter status
// ----------------------------------------------------------------------------
`define COUNTER_COUNT       4
`define SAMPLE_OVF_BIT      62
`define STATUS_RESET        64'h0000_0000_0000_0000
`define INCR_ZERO           8'h00
`define INCR_ONE            8'h01

`endif

// >>> common/offcore_filter_pkg.sv
// Purpose : shared types of the uncore request filter block
// Assumes : constants come from offcore_filter_defs.svh
// Notes   : types only
`include "offcore_filter_defs.svh"

package offcore_filter_pkg;
    typedef logic [63:0]                      filter_t;
    typedef logic [`REQ_MSB:`REQ_LSB]         req_class_t;
    typedef logic [`RESP_MSB-`RESP_LSB:0]     resp_class_t;
    typedef logic [`SNOOP_MSB-`SNOOP_LSB:0]   snoop_class_t;
    typedef logic [`COUNTER_COUNT-1:0]        counter_mask_t;
    typedef logic [7:0]                       increment_t;
endpackage : offcore_filter_pkg

// >>> dv/offcore_filter_sva.sv
// Purpose : port assertions for the uncore request filter block
// Assumes : one clock domain, reset_n active low
// Notes   : bound to the top module after endmodule
`timescale 1ns/1ps
`include "offcore_filter_defs.svh"

module offcore_filter_sva
    import offcore_filter_pkg::*;
(
    // clock, reset and register port
    input wire logic                              clk,
    input wire logic                              reset_n,
    input wire logic                              reg_read,
    input wire logic [31:0]                       reg_addr,
    input wire logic [63:0]                       reg_rdata,
    input wire logic                              reg_rvalid,
    // counting and sample status
    input wire logic [7:0]                        event_code,
    input wire logic                              sample_written,
    input wire logic [63:0]                       sample_write_pointer,
    input wire logic [63:0]                       sample_buffer_base,
    input wire logic [63:0]                       sample_buffer_limit,
    input wire offcore_filter_pkg::counter_mask_t applicable_counters,
    input wire offcore_filter_pkg::counter_mask_t counter_overflow,
    input wire logic [63:0]                       status_clear,
    input wire logic [63:0]                       global_counter_status,
    input wire offcore_filter_pkg::increment_t    counter_increment,
    input wire offcore_filter_pkg::counter_mask_t counter_reload
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    // record writes outside and inside the buffer bounds
    sequence s_oob;
        sample_written && (sample_write_pointer < sample_buffer_base ||
            sample_write_pointer > sample_buffer_limit);
    endsequence
    sequence s_inb;
        sample_written && sample_write_pointer >= sample_buffer_base &&
            sample_write_pointer <= sample_buffer_limit;
    endsequence

    // register port answers
    property p_read_ans; reg_read |=> reg_rvalid; endproperty
    a_read_ans: assert property (p_read_ans) else $error("read not answered");
    property p_no_ans; !reg_read |=> !reg_rvalid; endproperty
    a_no_ans: assert property (p_no_ans) else $error("answer without read");
    property p_unmapped; reg_read && reg_addr != `FILTER0_ADDR &&
        reg_addr != `FILTER1_ADDR |=> reg_rdata == 64'h0; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // sample buffer status
    property p_oob_flag; s_oob |=> global_counter_status[`SAMPLE_OVF_BIT]; endproperty
    a_oob_flag: assert property (p_oob_flag) else $error("flag not set");
    property p_oob_reload; s_oob |=> counter_reload == 4'h0; endproperty
    a_oob_reload: assert property (p_oob_reload) else $error("reload out of bounds");
    property p_oob_clear; s_oob ##0 counter_overflow == 4'h0 |=>
        (global_counter_status[3:0] & $past(applicable_counters)) == 4'h0; endproperty
    a_oob_clear: assert property (p_oob_clear) else $error("overflow not cleared");
    property p_inb_reload; s_inb |=> counter_reload == $past(applicable_counters);
    endproperty
    a_inb_reload: assert property (p_inb_reload) else $error("reload mask wrong");
    property p_reload_cause; !sample_written |=> counter_reload == 4'h0; endproperty
    a_reload_cause: assert property (p_reload_cause) else $error("reload without write");
    property p_flag_sticky; global_counter_status[62] && !status_clear[62] |=>
        global_counter_status[62]; endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");

    // counting only for the selected event
    property p_event_off; event_code != `OFFCORE_EVENT_CODE |=>
        counter_increment == 8'h00; endproperty
    a_event_off: assert property (p_event_off) else $error("count on other event");
endmodule : offcore_filter_sva

bind offcore_response_event_filter offcore_filter_sva u_sva (
    .clk(clk), .reset_n(reset_n), .reg_read(reg_read), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .event_code(event_code),
    .sample_written(sample_written), .sample_write_pointer(sample_write_pointer),
    .sample_buffer_base(sample_buffer_base), .sample_buffer_limit(sample_buffer_limit),
    .applicable_counters(applicable_counters), .counter_overflow(counter_overflow),
    .status_clear(status_clear), .global_counter_status(global_counter_status),
    .counter_increment(counter_increment), .counter_reload(counter_reload)
);

// >>> dv/offcore_response_event_filter_bench.sv
// Purpose : directed bench for the uncore request filter block
// Assumes : 10 MHz clock, inputs driven 1 ns after the rising edge
// Notes   : one task per scenario; wrap_up gives the verdict
`timescale 1ns/1ps
`include "offcore_filter_defs.svh"

module offcore_response_event_filter_bench;
    import offcore_filter_pkg::*;

    logic          clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic          txn_valid = 1'b0, queue_accept = 1'b0, queue_done = 1'b0, sampled = 1'b0;
    logic [31:0]   reg_addr = 32'h0;
    logic [63:0]   reg_wdata = 64'h0, ptr = 64'h0, status_clear = 64'h0;
    logic [63:0]   base = 64'h1000, thresh = 64'h1800, limit = 64'h1FFF;
    logic [7:0]    event_code = `OFFCORE_EVENT_CODE, unit_mask = `UNIT_MASK_FILTER0;
    req_class_t    txn_class = '0, acc_class = '0, done_class = '0;
    resp_class_t   txn_resp = '0;
    snoop_class_t  txn_snoop = '0;
    counter_mask_t applicable = '0, overflow = '0, reload;
    logic [63:0]   reg_rdata, status;
    logic          reg_rvalid;
    increment_t    incr;
    int            errors = 0, tests_run = 0;

    // 100 ns clock
    initial begin
        forever #50 clk = ~clk;
    end

    offcore_response_event_filter DUT (
        .clk(clk), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .event_code(event_code), .unit_mask(unit_mask),
        .txn_valid(txn_valid), .txn_class(txn_class), .txn_resp(txn_resp),
        .txn_snoop(txn_snoop), .queue_accept(queue_accept), .queue_accept_class(acc_class),
        .queue_done(queue_done), .queue_done_class(done_class), .sample_written(sampled),
        .sample_write_pointer(ptr), .sample_buffer_base(base),
        .sample_interrupt_threshold(thresh), .sample_buffer_limit(limit),
        .applicable_counters(applicable), .counter_overflow(overflow),
        .status_clear(status_clear), .global_counter_status(status),
        .counter_increment(incr), .counter_reload(reload)
    );

    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [31:0] a, input logic [63:0] d);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step;
        reg_write = 1'b0;
        step;
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [63:0] exp);
        reg_read = 1'b1;
        reg_addr = a;
        step;
        reg_read = 1'b0;
        check("rvalid", 64'(reg_rvalid), 64'h1);
        check("rdata", reg_rdata, exp);
        step;
    endtask : rd

    task automatic txn(input req_class_t c, input resp_class_t r, input snoop_class_t s,
                       input increment_t exp);
        txn_valid = 1'b1;
        txn_class = c;
        txn_resp = r;
        txn_snoop = s;
        step;
        txn_valid = 1'b0;
        check("increment", 64'(incr), 64'(exp));
        step;
    endtask : txn

    task automatic sample(input logic [63:0] p, input counter_mask_t app,
                          input logic [63:0] exp_st, input counter_mask_t exp_rl);
        ptr = p;
        applicable = app;
        sampled = 1'b1;
        step;
        sampled = 1'b0;
        check("status", status, exp_st);
        check("reload", 64'(reload), 64'(exp_rl));
        step;
    endtask : sample

    task automatic t_regs;
        rd(`FILTER0_ADDR, `FILTER_RESET);
        rd(`FILTER1_ADDR, `FILTER_RESET);
        wr(`FILTER0_ADDR, '1);
        wr(`FILTER1_ADDR, '1);
        wr(32'h0000_01A8, '1);
        rd(`FILTER0_ADDR, `FILTER0_WMASK);
        rd(`FILTER1_ADDR, `FILTER1_WMASK);
        rd(32'h0000_01A8, 64'h0);
    endtask : t_regs

    task automatic t_select;
        wr(`FILTER0_ADDR, 64'h0000_0000_0001_0001);
        wr(`FILTER1_ADDR, 64'h0000_0000_0001_0002);
        txn(16'h0001, 15'h0001, 7'h00, `INCR_ONE);
        txn(16'h0002, 15'h0001, 7'h00, `INCR_ZERO);
        unit_mask = `UNIT_MASK_FILTER1;
        txn(16'h0002, 15'h0001, 7'h00, `INCR_ONE);
        txn(16'h0001, 15'h0001, 7'h00, `INCR_ZERO);
        event_code = 8'hB6;
        txn(16'h0002, 15'h0001, 7'h00, `INCR_ZERO);
        event_code = `OFFCORE_EVENT_CODE;
        unit_mask = `UNIT_MASK_FILTER0;
    endtask : t_select

    task automatic t_classes;
        for (int i = 0; i < 16; i++) begin
            wr(`FILTER0_ADDR, 64'h1_0000 | (64'h1 << i));
            txn(16'h1 << i, 15'h0001, 7'h00, (i == 6) ? `INCR_ZERO : `INCR_ONE);
            if (i < 15) begin
                txn(16'h1 << (i + 1), 15'h0001, 7'h00, `INCR_ZERO);
            end
        end
        wr(`FILTER0_ADDR, 64'h0000_0002_0002_0003);
        txn(16'h0002, 15'h0000, 7'h04, `INCR_ONE);
        txn(16'h0001, 15'h0002, 7'h00, `INCR_ONE);
        txn(16'h0001, 15'h0004, 7'h00, `INCR_ZERO);
    endtask : t_classes

    task automatic t_snoop;
        int sn[4] = '{2, 3, 5, 6};
        foreach (sn[k]) begin
            wr(`FILTER0_ADDR, 64'h1 | (64'h1 << (31 + sn[k])));
            txn(16'h0001, 15'h0000, 7'h01 << sn[k], `INCR_ONE);
            txn(16'h0001, 15'h0000, 7'h00, `INCR_ZERO);
        end
        wr(`FILTER0_ADDR, 64'h0000_0000_0000_0001);
        txn(16'h0001, 15'h7FFF, 7'h7F, `INCR_ZERO);
        wr(`FILTER0_ADDR, 64'h0000_0000_0001_0000);
        txn(16'h0001, 15'h0001, 7'h00, `INCR_ZERO);
    endtask : t_snoop

    task automatic t_outstanding;
        wr(`FILTER0_ADDR, 64'h0000_0040_0000_0001);
        acc_class = 16'h0001;
        done_class = 16'h0001;
        queue_accept = 1'b1;
        step;
        step;
        queue_accept = 1'b0;
        step;
        check("pending two", 64'(incr), 64'h2);
        queue_done = 1'b1;
        step;
        queue_done = 1'b0;
        step;
        check("pending one", 64'(incr), 64'h1);
        acc_class = 16'h0002;
        queue_accept = 1'b1;
        queue_done = 1'b1;
        step;
        queue_accept = 1'b0;
        queue_done = 1'b0;
        step;
        check("pending none", 64'(incr), 64'h0);
        wr(`FILTER0_ADDR, 64'h0);
    endtask : t_outstanding

    task automatic t_sample;
        overflow = 4'h3;
        step;
        overflow = 4'h0;
        check("overflow bits", status, 64'h3);
        sample(64'h0FFF, 4'h1, 64'h4000_0000_0000_0002, 4'h0);
        sample(64'h2000, 4'h2, 64'h4000_0000_0000_0000, 4'h0);
        status_clear = '1;
        step;
        status_clear = '0;
        check("cleared", status, 64'h0);
        sample(64'h1000, 4'h1, 64'h0, 4'h1);
        sample(64'h1800, 4'h4, 64'h4000_0000_0000_0000, 4'h4);
    endtask : t_sample

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // watchdog well beyond the expected run
    initial begin
        #(100 * 2000);
        errors++;
        wrap_up;
    end

    // reset, then the scenarios in turn
    initial begin
        repeat (8) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (3) step;
        t_regs;
        t_select;
        t_classes;
        t_snoop;
        t_outstanding;
        t_sample;
        wrap_up;
    end
endmodule : offcore_response_event_filter_bench

// >>> logic/offcore_response_event_filter.sv
// Summary of operation
// - The sample overflow flag at status bit 62 sets when the write pointer reaches the threshold or leaves the buffer bounds.
// - An out-of-bounds pointer clears the overflow bits of the requesting counters and suppresses their reload.
// - Event B7 with unit mask 01 counts through filter 0 and with unit mask 02 through filter 1.
// - Each core owns its own pair of filter registers, one instance of this block per core.
// - Filter bits 15:0 select request classes, one bit per class.
// - Filter bits 30:16 select supplier or cache-hit response classes.
// - Filter bits 37:31 qualify second-level misses by snoop outcome.
// - Bit 38 accumulates outstanding-request cycles, software clears 37:16, and only filter 0 holds it.
// - Request bits 0 to 5 are demand data, demand ownership, fetch miss, writeback, prefetch read, prefetch ownership; bit 6 reserved.
// - Request bits 7 to 15 are partial read, partial write, uncacheable fetch, lock, full stream, soft prefetch, first-level prefetch, partial stream, any.
// - Snoop bits 33, 34, 36, 37 select true miss, peer hit no forward, peer modified hit, non-memory target; 32:31 and 35 reserved.
// - A filter with no request bit or no valid response pattern yields a count of zero.
// - A response pattern is valid when any response, hit, snoop or outstanding bit is set; a request needs a non-reserved bit.
// - Several request and response bits may be set together and count the combined class.
//
// Purpose : per-core uncore request filters and sample buffer overflow status
// Assumes : register port accesses are single-cycle; inputs synchronous to clk
// Notes   : counter_increment and counter_reload feed the programmable counters
`timescale 1ns/1ps
`include "offcore_filter_defs.svh"

module offcore_response_event_filter
    import offcore_filter_pkg::*;
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        reset_n,
    // register port
    input  wire logic                        reg_write,
    input  wire logic                        reg_read,
    input  wire logic [31:0]                 reg_addr,
    input  wire logic [63:0]                 reg_wdata,
    output      logic [63:0]                 reg_rdata,
    output      logic                        reg_rvalid,
    // counter event selection
    input  wire logic [7:0]                  event_code,
    input  wire logic [7:0]                  unit_mask,
    // completed uncore transaction
    input  wire logic                        txn_valid,
    input  wire offcore_filter_pkg::req_class_t   txn_class,
    input  wire offcore_filter_pkg::resp_class_t  txn_resp,
    input  wire offcore_filter_pkg::snoop_class_t txn_snoop,
    // request queue
    input  wire logic                        queue_accept,
    input  wire offcore_filter_pkg::req_class_t   queue_accept_class,
    input  wire logic                        queue_done,
    input  wire offcore_filter_pkg::req_class_t   queue_done_class,
    // sample buffer
    input  wire logic                        sample_written,
    input  wire logic [63:0]                 sample_write_pointer,
    input  wire logic [63:0]                 sample_buffer_base,
    input  wire logic [63:0]                 sample_interrupt_threshold,
    input  wire logic [63:0]                 sample_buffer_limit,
    input  wire offcore_filter_pkg::counter_mask_t applicable_counters,
    // counter overflow status
    input  wire offcore_filter_pkg::counter_mask_t counter_overflow,
    input  wire logic [63:0]                 status_clear,
    output      logic [63:0]                 global_counter_status,
    // programmable counter control
    output      offcore_filter_pkg::increment_t   counter_increment,
    output      offcore_filter_pkg::counter_mask_t counter_reload
);
    import offcore_filter_pkg::*;

    // -------------------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------------------
    logic rst_meta_n;
    logic rst_n;

    // asynchronous assert, two-stage synchronous release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // -------------------------------------------------------------------------
    // filter registers
    // -------------------------------------------------------------------------
    filter_t     filter0;
    filter_t     filter1;
    filter_t     next_filter0;
    filter_t     next_filter1;
    logic [63:0] next_rdata;
    logic        hit0;
    logic        hit1;

    assign hit0 = reg_addr == `FILTER0_ADDR;
    assign hit1 = reg_addr == `FILTER1_ADDR;

    // writes store only defined bits; filter 1 has no outstanding bit
    always_comb begin
        next_filter0 = filter0;
        next_filter1 = filter1;
        next_rdata   = reg_rdata;
        if (reg_write && hit0) begin
            next_filter0 = reg_wdata & `FILTER0_WMASK;
        end
        if (reg_write && hit1) begin
            next_filter1 = reg_wdata & `FILTER1_WMASK;
        end
        if (reg_read) begin
            next_rdata = hit0 ? filter0 : hit1 ? filter1 : `FILTER_RESET;
        end
    end

    // private to this core's instance
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filter0    <= `FILTER_RESET;
            filter1    <= `FILTER_RESET;
            reg_rdata  <= `FILTER_RESET;
            reg_rvalid <= 1'b0;
        end else begin
            filter0    <= next_filter0;
            filter1    <= next_filter1;
            reg_rdata  <= next_rdata;
            reg_rvalid <= reg_read;
        end
    end

    // -------------------------------------------------------------------------
    // transaction matching
    // -------------------------------------------------------------------------
    increment_t incr0;
    increment_t incr1;
    increment_t next_increment;

    // class positions fixed by the filter layout
    request_filter_match match0 (
        .clk                (clk),
        .rst_n              (rst_n),
        .filter             (filter0),
        .txn_valid          (txn_valid),
        .txn_class          (txn_class),
        .txn_resp           (txn_resp),
        .txn_snoop          (txn_snoop),
        .queue_accept       (queue_accept),
        .queue_accept_class (queue_accept_class),
        .queue_done         (queue_done),
        .queue_done_class   (queue_done_class),
        .increment          (incr0)
    );

    request_filter_match match1 (
        .clk                (clk),
        .rst_n              (rst_n),
        .filter             (filter1),
        .txn_valid          (txn_valid),
        .txn_class          (txn_class),
        .txn_resp           (txn_resp),
        .txn_snoop          (txn_snoop),
        .queue_accept       (queue_accept),
        .queue_accept_class (queue_accept_class),
        .queue_done         (queue_done),
        .queue_done_class   (queue_done_class),
        .increment          (incr1)
    );

    // unit mask picks which filter drives the counter; reserved snoop bits never store
    always_comb begin
        next_increment = `INCR_ZERO;
        if (event_code == `OFFCORE_EVENT_CODE) begin
            if (unit_mask == `UNIT_MASK_FILTER0) begin
                next_increment = incr0;
            end else if (unit_mask == `UNIT_MASK_FILTER1) begin
                next_increment = incr1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_increment <= `INCR_ZERO;
        end else begin
            counter_increment <= next_increment;
        end
    end

    // -------------------------------------------------------------------------
    // sample buffer status
    // -------------------------------------------------------------------------
    logic          out_of_bounds;
    logic          at_threshold;
    logic [63:0]   next_status;
    counter_mask_t next_reload;

    assign out_of_bounds = (sample_write_pointer < sample_buffer_base)
                         | (sample_write_pointer > sample_buffer_limit);
    assign at_threshold  = sample_write_pointer >= sample_interrupt_threshold;

    // hardware sets win over software clears in the same cycle
    always_comb begin
        next_status = global_counter_status & ~status_clear;
        next_reload = '0;
        if (sample_written) begin
            if (out_of_bounds) begin
                // no reload from the debug store area on a bad pointer
                next_status[`COUNTER_COUNT-1:0] = next_status[`COUNTER_COUNT-1:0]
                                                & ~applicable_counters;
            end else begin
                next_reload = applicable_counters;
            end
            if (out_of_bounds || at_threshold) begin
                next_status[`SAMPLE_OVF_BIT] = 1'b1;
            end
        end
        next_status[`COUNTER_COUNT-1:0] = next_status[`COUNTER_COUNT-1:0]
                                        | counter_overflow;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            global_counter_status <= `STATUS_RESET;
            counter_reload        <= '0;
        end else begin
            global_counter_status <= next_status;
            counter_reload        <= next_reload;
        end
    end
endmodule : offcore_response_event_filter

// >>> logic/request_filter_match.sv
// Purpose : matches uncore transactions against one filter and yields the counter increment
// Assumes : class vectors are one bit per class, aligned to the filter fields
// Notes   : increment is combinational; the top registers it
`timescale 1ns/1ps
`include "offcore_filter_defs.svh"

module request_filter_match
    import offcore_filter_pkg::*;
(
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // filter setting
    input  wire offcore_filter_pkg::filter_t      filter,
    // completed uncore transaction
    input  wire logic                       txn_valid,
    input  wire offcore_filter_pkg::req_class_t   txn_class,
    input  wire offcore_filter_pkg::resp_class_t  txn_resp,
    input  wire offcore_filter_pkg::snoop_class_t txn_snoop,
    // request queue acceptance and response arrival
    input  wire logic                       queue_accept,
    input  wire offcore_filter_pkg::req_class_t   queue_accept_class,
    input  wire logic                       queue_done,
    input  wire offcore_filter_pkg::req_class_t   queue_done_class,
    // amount to add this cycle
    output      offcore_filter_pkg::increment_t   increment
);
    import offcore_filter_pkg::*;

    increment_t pending;
    increment_t next_pending;
    logic       req_valid;
    logic       resp_valid;
    logic       req_hit;
    logic       resp_hit;
    logic       outstanding;
    logic       acc_hit;
    logic       done_hit;

    // -------------------------------------------------------------------------
    // selection checks
    // -------------------------------------------------------------------------
    // reserved bits never store, so any set bit is a legal one
    assign req_valid   = |filter[`REQ_MSB:`REQ_LSB];
    assign resp_valid  = |filter[`OUTSTANDING_BIT:`RESP_LSB];
    assign outstanding = filter[`OUTSTANDING_BIT];
    // any selected class matches, several may be set together
    assign req_hit     = |(txn_class & filter[`REQ_MSB:`REQ_LSB]);
    assign resp_hit    = |(txn_resp & filter[`RESP_MSB:`RESP_LSB])
                       | |(txn_snoop & filter[`SNOOP_MSB:`SNOOP_LSB]);
    assign acc_hit     = queue_accept & |(queue_accept_class & filter[`REQ_MSB:`REQ_LSB]);
    assign done_hit    = queue_done & |(queue_done_class & filter[`REQ_MSB:`REQ_LSB]);

    // -------------------------------------------------------------------------
    // outstanding request tracking
    // -------------------------------------------------------------------------
    // live from queue acceptance to response arrival
    always_comb begin
        next_pending = pending;
        if (acc_hit && !done_hit) begin
            next_pending = increment_t'(pending + `INCR_ONE);
        end else if (done_hit && !acc_hit && pending != `INCR_ZERO) begin
            next_pending = increment_t'(pending - `INCR_ONE);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending <= `INCR_ZERO;
        end else begin
            pending <= next_pending;
        end
    end

    // -------------------------------------------------------------------------
    // increment selection
    // -------------------------------------------------------------------------
    always_comb begin
        increment = `INCR_ZERO;
        if (req_valid && resp_valid) begin
            if (outstanding) begin
                increment = pending;
            end else if (txn_valid && req_hit && resp_hit) begin
                increment = `INCR_ONE;
            end
        end
    end
endmodule : request_filter_match
